// >>> logic/cpu_registers_and_flags.sv
`default_nettype none
module cpu_registers_and_flags (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire cpu_regs_pkg::cmd_e cmd,
   input wire cpu_regs_pkg::sel_e stk_sel,
   input wire logic [7:0] data_in,
   input wire logic pc_inc,
   input wire logic pc_load,
   input wire logic [15:0] pc_target,
   input wire logic flag_we,
   input wire logic flag_c_we,
   input wire cpu_regs_pkg::flags_s alu_flags,
   input wire logic irq_pin,
   input wire logic irq_start,
   input wire logic vec_fetch,
   input wire logic [15:0] vec_addr,
   output logic [7:0] acc,
   output logic [7:0] idx,
   output logic [15:0] sp,
   output logic [15:0] pc,
   output logic [7:0] ccr,
   output logic [7:0] stk_wdata,
   output logic irq_service,
   output logic [2:0] irq_step
);
   ////////////////////////////////////////////////////////////
   // interrupt entry sequencer
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_PCL = 7'b0000010,
      ST_PCH = 7'b0000100,
      ST_X = 7'b0001000,
      ST_A = 7'b0010000,
      ST_CC = 7'b0100000,
      ST_VEC = 7'b1000000
   } irq_st_e;

   irq_st_e st_r;
   logic irq_s1_r; // first synchroniser stage only
   logic irq_s2_r;
   logic pend; // latched request
   logic [7:0] acc_r;
   logic [7:0] idx_r;
   logic [5:0] sp_low_r; // only the low six bits exist
   logic [13:0] pc_r; // two top bits never stored
   logic h_r, i_r, n_r, z_r, c_r;
   logic [7:0] stk_wdata_r;
   logic irq_service_r;
   logic [2:0] irq_step_r;
   logic do_push, do_pull;
   logic entry_go;

   // pack the condition code byte, top bits fixed high
   function automatic logic [7:0] pack_cc(input logic h, i, n, z, c);
      pack_cc = {cpu_regs_pkg::CC_FIXED, h, i, n, z, c};
   endfunction

   ////////////////////////////////////////////////////////////
   // pin synchroniser: the first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_s1_r <= 1'b0;
         irq_s2_r <= 1'b0;
      end else begin
         irq_s1_r <= irq_pin;
         irq_s2_r <= irq_s1_r;
      end
   end

   irq_latch u_latch (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .irq_req(irq_s2_r),
      .irq_taken(entry_go),
      .irq_pend(pend)
   );

   // entry only starts while the mask is clear; else request waits
   assign entry_go = (st_r == ST_IDLE) && irq_start && pend && !i_r;

   // stack direction: entry pushes, sequencer pushes and pulls
   assign do_push = (cmd == cpu_regs_pkg::CMD_PUSH) ||
      (st_r inside {ST_PCL, ST_PCH, ST_X, ST_A, ST_CC});
   assign do_pull = (cmd == cpu_regs_pkg::CMD_PULL) && (st_r == ST_IDLE);

   ////////////////////////////////////////////////////////////
   // entry state machine: five pushes, then mask, then vector
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               if (entry_go) st_r <= ST_PCL;
            end
            ST_PCL: st_r <= ST_PCH;
            ST_PCH: st_r <= ST_X;
            ST_X: st_r <= ST_A;
            ST_A: st_r <= ST_CC;
            ST_CC: st_r <= ST_VEC; // five bytes in total
            ST_VEC: begin
               if (vec_fetch) st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // stack byte offered to memory during a push
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stk_wdata_r <= 8'h00;
      end else begin
         unique case (st_r)
            ST_PCL: stk_wdata_r <= {pc_r[7:0]};
            ST_PCH: stk_wdata_r <= {2'b00, pc_r[13:8]};
            ST_X: stk_wdata_r <= idx_r;
            ST_A: stk_wdata_r <= acc_r;
            ST_CC: stk_wdata_r <= pack_cc(h_r, i_r, n_r, z_r, c_r);
            default: begin
               unique case (stk_sel)
                  cpu_regs_pkg::SEL_PCL: stk_wdata_r <= pc_r[7:0];
                  cpu_regs_pkg::SEL_PCH: stk_wdata_r <= {2'b00, pc_r[13:8]};
                  cpu_regs_pkg::SEL_X: stk_wdata_r <= idx_r;
                  cpu_regs_pkg::SEL_A: stk_wdata_r <= acc_r;
                  default: stk_wdata_r <= pack_cc(h_r, i_r, n_r, z_r, c_r);
               endcase
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // stack pointer: six live bits, so wrap at the window ends is free
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sp_low_r <= cpu_regs_pkg::SP_RESET[5:0];
      end else if (cmd == cpu_regs_pkg::CMD_SP_RELOAD && st_r == ST_IDLE) begin
         sp_low_r <= cpu_regs_pkg::SP_RESET[5:0];
      end else if (do_push) begin
         sp_low_r <= sp_low_r - 6'h01; // wraps 00c0 to 00ff
      end else if (do_pull) begin
         sp_low_r <= sp_low_r + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////
   // accumulator and index: only the sequencer reaches them
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         acc_r <= cpu_regs_pkg::ACC_RESET;
      end else if (st_r == ST_IDLE && (cmd == cpu_regs_pkg::CMD_LOAD_A ||
                   (do_pull && stk_sel == cpu_regs_pkg::SEL_A))) begin
         acc_r <= data_in;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         idx_r <= cpu_regs_pkg::IDX_RESET;
      end else if (st_r == ST_IDLE && (cmd == cpu_regs_pkg::CMD_LOAD_X ||
                   (do_pull && stk_sel == cpu_regs_pkg::SEL_X))) begin
         idx_r <= data_in;
      end
   end

   ////////////////////////////////////////////////////////////
   // program counter: vector, then pulls, jumps, then increment
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= cpu_regs_pkg::PC_RESET[13:0];
      end else if (st_r == ST_VEC && vec_fetch) begin
         pc_r <= vec_addr[13:0];
      end else if (do_pull && stk_sel == cpu_regs_pkg::SEL_PCH) begin
         pc_r <= {data_in[5:0], pc_r[7:0]};
      end else if (do_pull && stk_sel == cpu_regs_pkg::SEL_PCL) begin
         pc_r <= {pc_r[13:8], data_in};
      end else if (st_r == ST_IDLE && pc_load) begin
         pc_r <= pc_target[13:0];
      end else if (st_r == ST_IDLE && pc_inc) begin
         pc_r <= pc_r + 14'h0001;
      end
   end

   ////////////////////////////////////////////////////////////
   // interrupt mask: set by reset and entry, cleared only by software
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         i_r <= cpu_regs_pkg::CC_RESET[cpu_regs_pkg::CC_I];
      end else if (st_r == ST_CC) begin
         i_r <= 1'b1; // mask after the stacking
      end else if (st_r == ST_IDLE && cmd == cpu_regs_pkg::CMD_SEI) begin
         i_r <= 1'b1;
      end else if (st_r == ST_IDLE && cmd == cpu_regs_pkg::CMD_CLI) begin
         i_r <= 1'b0;
      end else if (st_r == ST_IDLE && (cmd == cpu_regs_pkg::CMD_LOAD_CC ||
                   (do_pull && stk_sel == cpu_regs_pkg::SEL_CC))) begin
         i_r <= data_in[cpu_regs_pkg::CC_I]; // return restores
      end
   end

   ////////////////////////////////////////////////////////////
   // result flags: alu supplies values, the sequencer says which update
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         h_r <= cpu_regs_pkg::CC_RESET[cpu_regs_pkg::CC_H];
         n_r <= cpu_regs_pkg::CC_RESET[cpu_regs_pkg::CC_N];
         z_r <= cpu_regs_pkg::CC_RESET[cpu_regs_pkg::CC_Z];
         c_r <= cpu_regs_pkg::CC_RESET[cpu_regs_pkg::CC_C];
      end else if (st_r == ST_IDLE && (cmd == cpu_regs_pkg::CMD_LOAD_CC ||
                   (do_pull && stk_sel == cpu_regs_pkg::SEL_CC))) begin
         h_r <= data_in[cpu_regs_pkg::CC_H];
         n_r <= data_in[cpu_regs_pkg::CC_N];
         z_r <= data_in[cpu_regs_pkg::CC_Z];
         c_r <= data_in[cpu_regs_pkg::CC_C];
      end else if (st_r == ST_IDLE && flag_we) begin
         h_r <= alu_flags.h;
         n_r <= alu_flags.n;
         z_r <= alu_flags.z;
         if (flag_c_we) c_r <= alu_flags.c;
      end else if (st_r == ST_IDLE && flag_c_we) begin
         c_r <= alu_flags.c; // carry-only instructions
      end
   end

   ////////////////////////////////////////////////////////////
   // entry status seen by the sequencer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_service_r <= 1'b0;
         irq_step_r <= 3'h0;
      end else begin
         irq_service_r <= (st_r != ST_IDLE) || entry_go;
         unique case (st_r)
            ST_PCL: irq_step_r <= 3'h1;
            ST_PCH: irq_step_r <= 3'h2;
            ST_X: irq_step_r <= 3'h3;
            ST_A: irq_step_r <= 3'h4;
            ST_CC: irq_step_r <= 3'h5;
            default: irq_step_r <= 3'h0;
         endcase
      end
   end

   // registers leave only on dedicated ports, no address decode
   assign acc = acc_r;
   assign idx = idx_r;
   assign sp = {cpu_regs_pkg::SP_FIXED_HI, sp_low_r};
   assign pc = {2'b00, pc_r};
   assign ccr = pack_cc(h_r, i_r, n_r, z_r, c_r);
   assign stk_wdata = stk_wdata_r;
   assign irq_service = irq_service_r;
   assign irq_step = irq_step_r;

   ////////////////////////////////////////////////////////////
   // checks
   sp_window_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sp[15:6] == 10'h003) else $error("stack pointer left window");
   sp_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == cpu_regs_pkg::CMD_SP_RELOAD && st_r == ST_IDLE) |=> sp == cpu_regs_pkg::SP_RESET)
      else $error("stack reload failed");
   sp_push_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_push && cmd != cpu_regs_pkg::CMD_SP_RELOAD) |=> sp[5:0] == $past(sp[5:0]) - 6'h01)
      else $error("push did not decrement");
   entry_five_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      entry_go |=> (st_r == ST_PCL) ##4 (st_r == ST_CC) ##1 (sp[5:0] == $past(sp[5:0], 5) - 6'h05))
      else $error("entry not five bytes");
   mask_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_CC) |=> i_r && st_r == ST_VEC) else $error("mask not set at entry");
   mask_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($fell(i_r)) |-> $past(cmd == cpu_regs_pkg::CMD_CLI || cmd == cpu_regs_pkg::CMD_LOAD_CC ||
      cmd == cpu_regs_pkg::CMD_PULL)) else $error("mask cleared by hardware");
   no_entry_masked_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      i_r |-> !entry_go) else $error("entry while masked");
   cc_top_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ccr[7:5] == 3'h7) else $error("cc top bits not ones");
   pc_inc_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_IDLE && pc_inc && !pc_load && !do_pull) |=> pc[13:0] == $past(pc[13:0]) + 14'h0001)
      else $error("pc did not advance");

   ////////////////////////////////////////////////////////////
   // further checks on loads, the stack and the entry sequence
   // a pull always moves the pointer up one slot
   sp_pull_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      do_pull |=> sp[5:0] == $past(sp[5:0]) + 6'h01)
      else $error("pull did not increment");
   // a push from the window floor lands back at the top, no error
   sp_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_push && sp[5:0] == 6'h00) |=> sp == cpu_regs_pkg::SP_RESET)
      else $error("stack did not wrap");
   // accumulator takes the offered byte on a load
   acc_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_IDLE && cmd == cpu_regs_pkg::CMD_LOAD_A) |=> acc == $past(data_in))
      else $error("accumulator load lost");
   // index register takes the offered byte on a load
   idx_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_IDLE && cmd == cpu_regs_pkg::CMD_LOAD_X) |=> idx == $past(data_in))
      else $error("index load lost");
   // the pc must not move while its bytes are being stacked
   entry_pc_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r inside {ST_PCL, ST_PCH, ST_X, ST_A, ST_CC}) |=> pc == $past(pc))
      else $error("pc moved during entry");
   // the vector replaces the pc in one step, top bits dropped
   vec_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_VEC && vec_fetch) |=> pc[13:0] == $past(vec_addr[13:0]))
      else $error("vector not loaded");
   // a masked request stays pending until the mask opens
   pend_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (pend && i_r) |=> pend)
      else $error("masked request lost");
   // pulling the cc byte restores the mask and every flag
   cc_restore_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_pull && stk_sel == cpu_regs_pkg::SEL_CC) |=> ccr[4:0] == $past(data_in[4:0]))
      else $error("cc not restored");
   // the step count reads one after the low pc byte, the first push
   step_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_r == ST_PCL) |=> irq_step == 3'h1)
      else $error("entry step out of order");
endmodule
`default_nettype wire

// >>> shared/cpu_regs_pkg.sv
`default_nettype none
package cpu_regs_pkg;
   // register widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   // stack window: upper ten bits fixed, low six bits count
   localparam logic [15:0] SP_RESET = 16'h00ff;
   localparam logic [9:0] SP_FIXED_HI = 10'h003;
   localparam int SP_LOW_W = 6;
   // program counter: top two bits ignored internally
   localparam int PC_USED_W = 14;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] IDX_RESET = 8'h00;
   // condition code bit positions
   localparam int CC_H = 4;
   localparam int CC_I = 3;
   localparam int CC_N = 2;
   localparam int CC_Z = 1;
   localparam int CC_C = 0;
   localparam logic [2:0] CC_FIXED = 3'h7;
   localparam logic [4:0] CC_RESET = 5'h08;
   // stack bytes per frame
   localparam int CALL_BYTES = 2;
   localparam int IRQ_BYTES = 5;

   // result flags offered by the alu; their update enables are separate ports
   typedef struct packed {
      logic h;
      logic n;
      logic z;
      logic c;
   } flags_s;

   // sequencer command to the register file
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_LOAD_A = 4'h1,
      CMD_LOAD_X = 4'h2,
      CMD_PUSH = 4'h3,
      CMD_PULL = 4'h4,
      CMD_SP_RELOAD = 4'h5,
      CMD_CLI = 4'h6,
      CMD_SEI = 4'h7,
      CMD_LOAD_CC = 4'h8
   } cmd_e;

   // stack byte source / destination selects
   typedef enum logic [2:0] {
      SEL_PCL = 3'h0,
      SEL_PCH = 3'h1,
      SEL_X = 3'h2,
      SEL_A = 3'h3,
      SEL_CC = 3'h4
   } sel_e;
endpackage
`default_nettype wire

// >>> logic/irq_latch.sv
`default_nettype none
// pending interrupt latch: holds a request until entry takes it
module irq_latch (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic irq_req,
   input wire logic irq_taken,
   output logic irq_pend
);
   logic pend_r;
   // request set wins over the taking clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
      end else if (irq_req) begin
         pend_r <= 1'b1;
      end else if (irq_taken) begin
         pend_r <= 1'b0;
      end
   end
   assign irq_pend = pend_r;
endmodule
`default_nettype wire

// >>> testbench/stack_mem_model.sv
`default_nettype none
// stack ram model: keeps the 64-byte stack window that the block pushes into and pulls from
module stack_mem_model (
   input wire logic clk_sys,
   input wire logic [15:0] sp,
   input wire logic [7:0] stk_wdata,
   output logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [64]; // one byte per window slot
   logic [5:0] sp_last = 6'h3f; // slot seen at the last falling edge
   // a push shows as sp stepping down by one; the byte lands in the old slot
   // sampled on the falling edge so that sp and the push byte have both settled
   always @(negedge clk_sys) begin
      if (sp[5:0] == sp_last - 6'h1) begin
         mem[sp_last] <= stk_wdata;
      end
      sp_last <= sp[5:0];
   end
   // a pull reads the slot above the free one; the index wraps inside the window
   assign rd_data = mem[sp[5:0] + 6'h1];
endmodule
`default_nettype wire

// >>> testbench/cpu_registers_and_flags_bench.sv
`default_nettype none
// bench: plays the sequencer, drives commands on the falling edge, judges registers
module cpu_registers_and_flags_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_b, use_mem, pc_inc, pc_load, flag_we, flag_c_we, irq_pin, irq_start, vec_fetch;
   cpu_regs_pkg::cmd_e cmd;
   cpu_regs_pkg::sel_e stk_sel;
   cpu_regs_pkg::flags_s alu_flags;
   logic [15:0] pc_target, vec_addr, sp, pc;
   logic [7:0] ld_val, rd_data, data_in, acc, idx, ccr, stk_wdata;
   logic irq_service;
   logic [2:0] irq_step;
   int comparisons = 0;
   int n_mismatch = 0;
   int cycles = 0;
   // pulled bytes come from the stack model, loads from the bench
   assign data_in = use_mem ? rd_data : ld_val;

   cpu_registers_and_flags dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd), .stk_sel(stk_sel),
      .data_in(data_in), .pc_inc(pc_inc), .pc_load(pc_load), .pc_target(pc_target), .flag_we(flag_we),
      .flag_c_we(flag_c_we), .alu_flags(alu_flags), .irq_pin(irq_pin), .irq_start(irq_start),
      .vec_fetch(vec_fetch), .vec_addr(vec_addr), .acc(acc), .idx(idx), .sp(sp), .pc(pc), .ccr(ccr),
      .stk_wdata(stk_wdata), .irq_service(irq_service), .irq_step(irq_step));
   stack_mem_model stk_u (.clk_sys(clk_sys), .sp(sp), .stk_wdata(stk_wdata), .rd_data(rd_data));

   ////////////////////////////////////////////////////////////////
   // one comparison, counted; unknowns never match
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one command for one cycle; the next falling edge sees its result
   task automatic step(input cpu_regs_pkg::cmd_e c, input cpu_regs_pkg::sel_e s = cpu_regs_pkg::SEL_A);
      cmd = c;
      stk_sel = s;
      @(negedge clk_sys);
      cmd = cpu_regs_pkg::CMD_NONE;
   endtask
   // reset held four cycles, asserted away from the rising edge
   task automatic t_reset();
      rst_b = 1'b0;
      repeat (4) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      check("acc", 16'h0000, acc);
      check("idx", 16'h0000, idx);
      check("sp", 16'h00ff, sp);
      check("pc", 16'h0000, pc);
      check("ccr", 16'h00e8, ccr);
   endtask
   // one flag update; c only moves when its own enable is up
   task automatic t_flag(input logic [3:0] f, input logic cwe, input logic [7:0] exp);
      alu_flags = f;
      flag_we = 1'b1;
      flag_c_we = cwe;
      @(negedge clk_sys);
      flag_we = 1'b0;
      flag_c_we = 1'b0;
      check("ccr flags", exp, ccr);
   endtask

   ////////////////////////////////////////////////////////////////
   // loads, pushes, pulls, then the full window and its wrap
   task automatic t_stack();
      ld_val = 8'ha5;
      step(cpu_regs_pkg::CMD_LOAD_A);
      ld_val = 8'h5a;
      step(cpu_regs_pkg::CMD_LOAD_X);
      check("acc load", 16'h00a5, acc);
      check("idx load", 16'h005a, idx);
      step(cpu_regs_pkg::CMD_PUSH, cpu_regs_pkg::SEL_A);
      step(cpu_regs_pkg::CMD_PUSH, cpu_regs_pkg::SEL_X);
      @(negedge clk_sys);
      check("sp push", 16'h00fd, sp);
      check("stack byte", 16'h00a5, stk_u.mem[6'h3f]);
      use_mem = 1'b1;
      step(cpu_regs_pkg::CMD_PULL, cpu_regs_pkg::SEL_A);
      step(cpu_regs_pkg::CMD_PULL, cpu_regs_pkg::SEL_X);
      use_mem = 1'b0;
      check("acc pull", 16'h005a, acc);
      check("idx pull", 16'h00a5, idx);
      check("sp pull", 16'h00ff, sp);
      repeat (63) step(cpu_regs_pkg::CMD_PUSH);
      check("sp floor", 16'h00c0, sp);
      step(cpu_regs_pkg::CMD_PUSH);
      check("sp wrap", 16'h00ff, sp);
      step(cpu_regs_pkg::CMD_PUSH);
      step(cpu_regs_pkg::CMD_SP_RELOAD);
      check("sp reload", 16'h00ff, sp);
   endtask
   // pc load drops the top bits, counts on, and a load beats an increment
   task automatic t_pc();
      pc_target = 16'hd234;
      pc_load = 1'b1;
      @(negedge clk_sys);
      pc_load = 1'b0;
      check("pc load", 16'h1234, pc);
      pc_inc = 1'b1;
      repeat (3) @(negedge clk_sys);
      check("pc inc", 16'h1237, pc);
      pc_target = 16'h2345;
      pc_load = 1'b1;
      @(negedge clk_sys);
      pc_load = 1'b0;
      pc_inc = 1'b0;
      check("pc jump", 16'h2345, pc);
   endtask
   // masked request waits; unmask lets it in; five bytes stacked, then returned
   task automatic t_irq();
      int n;
      cpu_regs_pkg::sel_e order [5];
      order = '{cpu_regs_pkg::SEL_CC, cpu_regs_pkg::SEL_A, cpu_regs_pkg::SEL_X, cpu_regs_pkg::SEL_PCH,
         cpu_regs_pkg::SEL_PCL};
      n = 0;
      irq_pin = 1'b1;
      irq_start = 1'b1;
      repeat (4) @(negedge clk_sys);
      irq_pin = 1'b0;
      repeat (6) @(negedge clk_sys);
      check("masked entry", 16'h0000, irq_service);
      step(cpu_regs_pkg::CMD_CLI);
      while (irq_service !== 1'b1 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      irq_start = 1'b0;
      @(negedge clk_sys);
      check("irq step", 16'h0001, irq_step);
      // the mask rises only once the last byte has gone out
      while (ccr[3] !== 1'b1 && n < 30) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      check("sp entry", 16'h00fa, sp);
      check("push pcl", 16'h0045, stk_u.mem[6'h3f]);
      check("push pch", 16'h0023, stk_u.mem[6'h3e]);
      check("push x", 16'h00a5, stk_u.mem[6'h3d]);
      check("push a", 16'h005a, stk_u.mem[6'h3c]);
      check("push cc", 16'h00e5, stk_u.mem[6'h3b]);
      vec_addr = 16'h3ff8;
      vec_fetch = 1'b1;
      @(negedge clk_sys);
      vec_fetch = 1'b0;
      check("pc vector", 16'h3ff8, pc);
      n = 0;
      while (irq_service !== 1'b0 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      ld_val = 8'h00;
      step(cpu_regs_pkg::CMD_LOAD_A);
      use_mem = 1'b1;
      foreach (order[i]) step(cpu_regs_pkg::CMD_PULL, order[i]);
      use_mem = 1'b0;
      check("ccr return", 16'h00e5, ccr);
      check("acc return", 16'h005a, acc);
      check("pc return", 16'h2345, pc);
      check("sp return", 16'h00ff, sp);
      step(cpu_regs_pkg::CMD_SEI);
      check("ccr mask set", 16'h00ed, ccr);
      ld_val = 8'h17;
      step(cpu_regs_pkg::CMD_LOAD_CC);
      check("ccr load", 16'h00f7, ccr);
   endtask

   ////////////////////////////////////////////////////////////////
   // 4 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // hang guard: the run needs about 120 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         results();
      end
   end
   // main sequence; every input has a value at time zero
   initial begin
      {use_mem, pc_inc, pc_load, flag_we, flag_c_we, irq_pin, irq_start, vec_fetch} = 8'h00;
      cmd = cpu_regs_pkg::CMD_NONE;
      stk_sel = cpu_regs_pkg::SEL_A;
      alu_flags = 4'h0;
      pc_target = 16'h0000;
      vec_addr = 16'h0000;
      ld_val = 8'h00;
      t_reset();
      t_stack();
      t_flag(4'hf, 1'b1, 8'hff);
      t_flag(4'h0, 1'b0, 8'he9);
      t_flag(4'ha, 1'b1, 8'hfa);
      t_flag(4'h5, 1'b1, 8'hed);
      t_pc();
      t_irq();
      t_reset();
      results();
   end
endmodule
`default_nettype wire
